// File: rtl/usdp_top.v
// Shadow receive/transmit data port of a UART with register slave and interrupt
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "usdp_defs.vh"
module usdp_top #(
	parameter DEPTH = `USDP_FIFO_DEPTH,
	parameter AW = `USDP_FIFO_AW
) (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Register port
	input wire [31:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// Receiver side: characters from the deserialiser
	input wire rx_char_valid,
	input wire [7:0] rx_char_uart,
	input wire [7:0] rx_char_ir,
	// Transmitter side: serialiser takes a character
	input wire tx_char_take,
	output reg tx_char_valid,
	output reg [7:0] tx_char,
	output reg tx_ir_sel,
	// Status and interrupt
	output reg rx_data_ready_flag,
	output reg tx_holding_empty_flag,
	output reg irq
);
	// Control and status
	reg fifo_en_ff;
	reg ir_mode_ff;
	reg overrun_ff;
	reg [`USDP_EV_W-1:0] istat_ff;
	reg [`USDP_EV_W-1:0] imask_ff;
	// Non-FIFO holding registers
	reg [7:0] rx_hold_ff;
	reg rx_hold_vld_ff;
	reg [7:0] tx_hold_ff;
	reg tx_hold_vld_ff;
	// Decoded accesses
	wire hit_data;
	wire rd_data;
	wire wr_data;
	wire wr_ctrl;
	wire wr_istat;
	wire wr_imask;
	wire [7:0] rx_sel;
	wire fifo_mode_change;
	// FIFO wiring
	wire [7:0] rxf_head;
	wire rxf_empty;
	wire rxf_full;
	wire [7:0] txf_head;
	wire txf_empty;
	wire txf_full;
	wire rx_ready;
	wire tx_ready;
	wire [7:0] rx_head;
	wire [7:0] tx_head;
	wire ev_overrun;
	wire ev_rxdata;
	wire ev_tx_holding_empty_flag;
	wire tx_holding_empty_flag_now;
	wire [`USDP_EV_W-1:0] events;
	reg [31:0] nxt_rdata;

	// Register decode
	assign hit_data = (reg_addr == `USDP_OFS_DATA);
	assign rd_data = reg_rd & hit_data;
	assign wr_data = reg_wr & hit_data;
	assign wr_ctrl = reg_wr & (reg_addr == `USDP_OFS_CTRL);
	assign wr_istat = reg_wr & (reg_addr == `USDP_OFS_ISTAT);
	assign wr_imask = reg_wr & (reg_addr == `USDP_OFS_IMASK);
	assign fifo_mode_change = wr_ctrl & (reg_wdata[`USDP_CTRL_FIFO_EN] != fifo_en_ff);

	// Receive source follows the selected mode
	assign rx_sel = ir_mode_ff ? rx_char_ir : rx_char_uart;

	// Receive FIFO, pushed only in FIFO mode, popped by a data read
	usdp_fifo #(
		.DEPTH(DEPTH),
		.AW(AW)
	) u_rxf (
		.core_clk(core_clk),
		.rst(rst),
		.clr(fifo_mode_change),
		.push(fifo_en_ff & rx_char_valid),
		.push_data(rx_sel),
		.pop(fifo_en_ff & rd_data),
		.head(rxf_head),
		.empty(rxf_empty),
		.full(rxf_full)
	);

	// Transmit FIFO, pushed by a data write, popped by the serialiser
	usdp_fifo #(
		.DEPTH(DEPTH),
		.AW(AW)
	) u_txf (
		.core_clk(core_clk),
		.rst(rst),
		.clr(fifo_mode_change),
		.push(fifo_en_ff & wr_data),
		.push_data(reg_wdata[7:0]),
		.pop(fifo_en_ff & tx_char_take),
		.head(txf_head),
		.empty(txf_empty),
		.full(txf_full)
	);

	// Mode-dependent views
	assign rx_ready = fifo_en_ff ? ~rxf_empty : rx_hold_vld_ff;
	assign rx_head = fifo_en_ff ? rxf_head : rx_hold_ff;
	assign tx_ready = fifo_en_ff ? ~txf_empty : tx_hold_vld_ff;
	assign tx_head = fifo_en_ff ? txf_head : tx_hold_ff;
	assign tx_holding_empty_flag_now = fifo_en_ff ? txf_empty : ~tx_hold_vld_ff;

	// Events
	assign ev_overrun = rx_char_valid & (fifo_en_ff ? (rxf_full & ~rd_data)
		: (rx_hold_vld_ff & ~rd_data));
	assign ev_rxdata = rx_char_valid;
	assign ev_tx_holding_empty_flag = tx_holding_empty_flag_now & ~tx_holding_empty_flag;
	assign events = {ev_tx_holding_empty_flag, ev_rxdata, ev_overrun};

	// Control register
	always @(posedge core_clk) begin
		if (rst) begin
			fifo_en_ff <= 1'b0;
			ir_mode_ff <= 1'b0;
		end else if (wr_ctrl) begin
			fifo_en_ff <= reg_wdata[`USDP_CTRL_FIFO_EN];
			ir_mode_ff <= reg_wdata[`USDP_CTRL_IR_MODE];
		end
	end

	// Non-FIFO receive holding register
	always @(posedge core_clk) begin
		if (rst) begin
			rx_hold_ff <= `USDP_DATA_RST;
			rx_hold_vld_ff <= 1'b0;
		end else if (fifo_mode_change | fifo_en_ff) begin
			rx_hold_vld_ff <= 1'b0;
		end else if (rx_char_valid) begin
			rx_hold_ff <= rx_sel;
			rx_hold_vld_ff <= 1'b1;
		end else if (rd_data) begin
			rx_hold_vld_ff <= 1'b0;
		end
	end

	// Non-FIFO transmit holding register
	always @(posedge core_clk) begin
		if (rst) begin
			tx_hold_ff <= `USDP_DATA_RST;
			tx_hold_vld_ff <= 1'b0;
		end else if (fifo_mode_change | fifo_en_ff) begin
			tx_hold_vld_ff <= 1'b0;
		end else if (wr_data) begin
			tx_hold_ff <= reg_wdata[7:0];
			tx_hold_vld_ff <= 1'b1;
		end else if (tx_char_take) begin
			tx_hold_vld_ff <= 1'b0;
		end
	end

	// Sticky overrun, cleared by reading the status register
	always @(posedge core_clk) begin
		if (rst) begin
			overrun_ff <= 1'b0;
		end else if (ev_overrun) begin
			overrun_ff <= 1'b1;
		end else if (reg_rd & (reg_addr == `USDP_OFS_STAT)) begin
			overrun_ff <= 1'b0;
		end
	end

	// Interrupt status, mask and output; set wins over clear
	always @(posedge core_clk) begin
		if (rst) begin
			istat_ff <= {`USDP_EV_W{1'b0}};
			imask_ff <= {`USDP_EV_W{1'b0}};
			irq <= 1'b0;
		end else begin
			istat_ff <= (istat_ff & ~(wr_istat ? reg_wdata[`USDP_EV_W-1:0]
				: {`USDP_EV_W{1'b0}})) | events;
			if (wr_imask) begin
				imask_ff <= reg_wdata[`USDP_EV_W-1:0];
			end
			irq <= |(istat_ff & imask_ff);
		end
	end

	// Registered status and transmit outputs
	always @(posedge core_clk) begin
		if (rst) begin
			rx_data_ready_flag <= 1'b0;
			tx_holding_empty_flag <= 1'b1;
			tx_char_valid <= 1'b0;
			tx_char <= `USDP_DATA_RST;
			tx_ir_sel <= 1'b0;
		end else begin
			rx_data_ready_flag <= rx_ready;
			tx_holding_empty_flag <= tx_holding_empty_flag_now;
			tx_char_valid <= tx_ready;
			tx_char <= tx_head;
			tx_ir_sel <= ir_mode_ff;
		end
	end

	// Read mux
	always @* begin
		nxt_rdata = 32'h00000000;
		case (reg_addr)
			`USDP_OFS_DATA: nxt_rdata[7:0] = rx_head;
			`USDP_OFS_CTRL: begin
				nxt_rdata[`USDP_CTRL_FIFO_EN] = fifo_en_ff;
				nxt_rdata[`USDP_CTRL_IR_MODE] = ir_mode_ff;
			end
			`USDP_OFS_STAT: begin
				nxt_rdata[`USDP_STAT_DR] = rx_ready;
				nxt_rdata[`USDP_STAT_OE] = overrun_ff;
				nxt_rdata[`USDP_STAT_TX_HOLDING_EMPTY_FLAG] = tx_holding_empty_flag_now;
				nxt_rdata[`USDP_STAT_TFULL] = txf_full;
				nxt_rdata[`USDP_STAT_RFULL] = rxf_full;
			end
			`USDP_OFS_ISTAT: nxt_rdata[`USDP_EV_W-1:0] = istat_ff;
			`USDP_OFS_IMASK: nxt_rdata[`USDP_EV_W-1:0] = imask_ff;
			default: nxt_rdata = 32'h00000000;
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			reg_rdata <= nxt_rdata;
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end
endmodule // usdp_top

// File: rtl/usdp_defs.vh
// Offsets, field positions, reset values and depths of the shadow data port
`ifndef USDP_DEFS_VH
`define USDP_DEFS_VH
`define USDP_ADDR_W 32
`define USDP_OFS_DATA 32'h5000114C
`define USDP_OFS_CTRL 32'h50001180
`define USDP_OFS_STAT 32'h50001184
`define USDP_OFS_ISTAT 32'h50001188
`define USDP_OFS_IMASK 32'h5000118C
`define USDP_OFS_RXSIDE 32'h50001190
`define USDP_OFS_TXPOP 32'h50001194
`define USDP_CTRL_FIFO_EN 0
`define USDP_CTRL_IR_MODE 1
`define USDP_STAT_DR 0
`define USDP_STAT_OE 1
`define USDP_STAT_TX_HOLDING_EMPTY_FLAG 5
`define USDP_STAT_TFULL 6
`define USDP_STAT_RFULL 7
`define USDP_EV_OE 0
`define USDP_EV_RXDATA 1
`define USDP_EV_TX_HOLDING_EMPTY_FLAG 2
`define USDP_EV_W 3
`define USDP_DATA_RST 8'h00
`define USDP_FIFO_DEPTH 16
`define USDP_FIFO_AW 4
`endif

// File: rtl/usdp_fifo.v
// Byte FIFO with honest full and empty flags
`timescale 1ns/1ps
`include "usdp_defs.vh"
module usdp_fifo #(
	parameter DEPTH = `USDP_FIFO_DEPTH,
	parameter AW = `USDP_FIFO_AW
) (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Control
	input wire clr,
	input wire push,
	input wire [7:0] push_data,
	input wire pop,
	// Status
	output wire [7:0] head,
	output wire empty,
	output wire full
);
	reg [7:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0] wp_ff;
	reg [AW-1:0] rp_ff;
	reg [AW:0] cnt_ff;
	wire do_push;
	wire do_pop;
	localparam integer DEPTH_I = DEPTH;
	localparam integer LAST_I = DEPTH - 1;
	// Depth and last index cut to the count and pointer widths on purpose
	localparam [AW:0] DEPTH_C = DEPTH_I[AW:0];
	localparam [AW-1:0] LAST = LAST_I[AW-1:0];

	// Push refused when full, pop refused when empty
	assign empty = (cnt_ff == {(AW+1){1'b0}});
	assign full = (cnt_ff == DEPTH_C);
	assign do_push = push & ~full;
	assign do_pop = pop & ~empty;
	assign head = mem_ff[rp_ff];

	// Storage
	always @(posedge core_clk) begin
		if (do_push) begin
			mem_ff[wp_ff] <= push_data;
		end
	end

	// Pointers and count
	always @(posedge core_clk) begin
		if (rst | clr) begin
			wp_ff <= {AW{1'b0}};
			rp_ff <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
		end else begin
			if (do_push) begin
				wp_ff <= (wp_ff == LAST) ? {AW{1'b0}} : wp_ff + 1'b1;
			end
			if (do_pop) begin
				rp_ff <= (rp_ff == LAST) ? {AW{1'b0}} : rp_ff + 1'b1;
			end
			if (do_push & ~do_pop) begin
				cnt_ff <= cnt_ff + 1'b1;
			end else if (do_pop & ~do_push) begin
				cnt_ff <= cnt_ff - 1'b1;
			end
		end
	end
endmodule // usdp_fifo

// File: tb/usdp_top_monitor.sv
// Port checker of the shadow data port
`timescale 1ns/1ps
`include "usdp_defs.vh"
module usdp_monitor (
	// Clock, reset and register port
	input wire core_clk,
	input wire rst,
	input wire [31:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	// Links and flags
	input wire rx_char_valid,
	input wire tx_char_take,
	input wire tx_char_valid,
	input wire [7:0] tx_char,
	input wire tx_ir_sel,
	input wire rx_data_ready_flag,
	input wire tx_holding_empty_flag
);
	reg fen_ff;
	reg ir_ff;
	wire dat = reg_addr == `USDP_OFS_DATA;
	wire quiet = !reg_wr && !tx_char_take;
	// Mirror of the mode bits
	always @(posedge core_clk) begin
		if (rst) begin
			fen_ff <= 1'b0;
			ir_ff <= 1'b0;
		end else if (reg_wr && reg_addr == `USDP_OFS_CTRL) begin
			fen_ff <= reg_wdata[`USDP_CTRL_FIFO_EN];
			ir_ff <= reg_wdata[`USDP_CTRL_IR_MODE];
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data not zero");
	a_upper_zero: assert property (reg_rd && dat |=> reg_rdata[31:8] == 24'h0)
		else $error("upper data bits set");
	a_unmapped_zero: assert property (reg_rd && !(reg_addr inside {`USDP_OFS_DATA,
		`USDP_OFS_CTRL, `USDP_OFS_STAT, `USDP_OFS_ISTAT, `USDP_OFS_IMASK, `USDP_OFS_RXSIDE,
		`USDP_OFS_TXPOP}) |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_write_clears_tx_holding_empty_flag: assert property (!fen_ff && reg_wr && dat ##1 !reg_wr |=>
		!tx_holding_empty_flag)
		else $error("holding empty after write");
	a_rx_sets_ready: assert property (rx_char_valid && !reg_rd && !reg_wr ##1 !reg_rd && !reg_wr
		|=> rx_data_ready_flag)
		else $error("data ready missing");
	a_read_clears_ready: assert property (!fen_ff && reg_rd && dat && !rx_char_valid ##1
		!rx_char_valid |=> !rx_data_ready_flag)
		else $error("data ready kept");
	a_tx_char_holds: assert property (quiet && $past(quiet) && tx_char_valid |=>
		tx_char_valid && $stable(tx_char))
		else $error("pending char changed");
	a_ir_path_sel: assert property (ir_ff == $past(ir_ff) |-> tx_ir_sel == ir_ff)
		else $error("output path wrong");
	cover property (rx_char_valid && rx_data_ready_flag);
	cover property (tx_char_take && tx_char_valid);
	cover property (reg_rd && dat ##1 reg_rdata != 32'h0);
endmodule // usdp_monitor
bind usdp_top usdp_monitor mon (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.rx_char_valid(rx_char_valid), .tx_char_take(tx_char_take), .tx_char_valid(tx_char_valid),
	.tx_char(tx_char), .tx_ir_sel(tx_ir_sel), .rx_data_ready_flag(rx_data_ready_flag),
	.tx_holding_empty_flag(tx_holding_empty_flag));

// File: tb/usdp_ser_model.sv
// Serialiser model consuming pending characters
`timescale 1ns/1ps
module usdp_ser_model (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Pace
	input wire stall,
	input wire [3:0] lag,
	// Transmit link
	input wire tx_char_valid,
	output reg tx_char_take
);
	reg [3:0] wait_ff;
	// Take, then stay off past the valid lag
	always @(posedge core_clk) begin
		if (rst) begin
			tx_char_take <= 1'b0;
			wait_ff <= 4'h0;
		end else if (tx_char_take || wait_ff != 4'h0) begin
			tx_char_take <= 1'b0;
			wait_ff <= tx_char_take ? lag + 4'h2 : wait_ff - 4'h1;
		end else begin
			tx_char_take <= tx_char_valid && !stall;
		end
	end
endmodule // usdp_ser_model

// File: tb/tb_usdp_top.sv
// Bench of the shadow data port
`timescale 1ns/1ps
`include "usdp_defs.vh"
module tb_usdp_top;
	reg core_clk = 1'b0;
	reg rst = 1'b1;
	reg [31:0] reg_addr = 32'h0;
	reg [31:0] reg_wdata = 32'h0;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg rx_char_valid = 1'b0;
	reg [7:0] rx_char_uart = 8'h0;
	reg [7:0] rx_char_ir = 8'h0;
	reg stall = 1'b0;
	reg [3:0] lag = 4'h0;
	reg rd_q = 1'b0;
	reg [31:0] seed = 32'h1780;
	reg [7:0] d;
	wire [31:0] reg_rdata;
	wire [7:0] tx_char;
	wire tx_char_take, tx_char_valid, tx_ir_sel, rx_data_ready_flag, tx_holding_empty_flag, irq;
	logic [31:0] rq[$];
	logic [7:0] tq[$];
	logic [7:0] xq[$];
	int error_cnt = 0;
	int tests_run = 0;
	usdp_top #(.DEPTH(4), .AW(2)) dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_char_valid(rx_char_valid), .rx_char_uart(rx_char_uart), .rx_char_ir(rx_char_ir),
		.tx_char_take(tx_char_take), .tx_char_valid(tx_char_valid), .tx_char(tx_char),
		.tx_ir_sel(tx_ir_sel), .rx_data_ready_flag(rx_data_ready_flag),
		.tx_holding_empty_flag(tx_holding_empty_flag), .irq(irq));
	usdp_ser_model ser (.core_clk(core_clk), .rst(rst), .stall(stall), .lag(lag),
		.tx_char_valid(tx_char_valid), .tx_char_take(tx_char_take));
	// Clock
	initial forever #5 core_clk = ~core_clk;
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s exp %h seen %h", what, exp, seen);
		end
	endtask
	function automatic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task wr(input [31:0] a, input [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		cyc(1);
		reg_wr <= 1'b0;
		cyc(1);
	endtask
	task rd(input [31:0] a, input [31:0] e);
		rq.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		cyc(1);
		reg_rd <= 1'b0;
		cyc(1);
	endtask
	task rx(input [7:0] u);
		rx_char_uart <= u;
		rx_char_ir <= ~u;
		rx_char_valid <= 1'b1;
		cyc(1);
		rx_char_valid <= 1'b0;
		cyc(1);
	endtask
	task final_report;
		if (error_cnt == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Read data and taken characters against notes
	always @(posedge core_clk) begin
		if (rd_q) chk(reg_rdata, rq.pop_front(), "rdata");
		if (tx_char_take && tx_char_valid) chk(tx_char, tq.size() ? tq.pop_front() : 'x, "tx");
		rd_q <= reg_rd;
	end
	// Watchdog
	initial begin
		cyc(3000);
		error_cnt++;
		final_report;
	end
	// Main sequence
	initial begin
		cyc(16);
		rst <= 1'b0;
		cyc(1);
		rd(`USDP_OFS_DATA, 32'h0);
		chk(tx_holding_empty_flag, 1, "tx_holding_empty_flag");
		stall <= 1'b1;
		wr(`USDP_OFS_DATA, {24'hFFFFFF, rnd()});
		cyc(1);
		chk(tx_holding_empty_flag, 0, "tx_holding_empty_flag");
		d = rnd();
		wr(`USDP_OFS_DATA, d);
		tq.push_back(d);
		stall <= 1'b0;
		cyc(9);
		rx(rnd());
		d = rnd();
		rx(d);
		chk(rx_data_ready_flag, 1, "ready");
		rd(`USDP_OFS_DATA, d);
		rd(`USDP_OFS_STAT, 32'h22);
		chk(irq, 0, "irq");
		wr(`USDP_OFS_IMASK, 1);
		cyc(1);
		chk(irq, 1, "irq");
		wr(`USDP_OFS_ISTAT, 7);
		cyc(1);
		chk(irq, 0, "irq");
		wr(`USDP_OFS_CTRL, 1);
		for (int i = 0; i < 5; i++) begin
			d = rnd();
			rx(d);
			if (i < 4) xq.push_back(d);
		end
		foreach (xq[i]) rd(`USDP_OFS_DATA, xq[i]);
		rd(`USDP_OFS_STAT, 32'h22);
		stall <= 1'b1;
		lag <= 4'h3;
		for (int i = 0; i < 5; i++) begin
			d = rnd();
			wr(`USDP_OFS_DATA, d);
			if (i < 4) tq.push_back(d);
		end
		rd(`USDP_OFS_STAT, 32'h40);
		stall <= 1'b0;
		cyc(60);
		wr(`USDP_OFS_CTRL, 3);
		d = rnd();
		rx(d);
		rd(`USDP_OFS_DATA, {24'h000000, ~d});
		chk(tx_ir_sel, 1, "ir");
		wr(`USDP_OFS_DATA, d);
		tq.push_back(d);
		rd(32'h50001000, 0);
		cyc(20);
		chk(tq.size(), 0, "txleft");
		final_report;
	end
endmodule // tb_usdp_top
